// *** cxl_pkg.sv ***
/*
  Constants for the core exception and latency unit.
  Assumes a single core clock domain and no software-visible registers.
*/
// What the document requires of this block
// RULE_01: Five exception classes, each own privileged mode
// RULE_02: Fast interrupt beats normal interrupt
// RULE_03: Fixed priority order and vector addresses
// RULE_04: Undefined and trap share lowest level
// RULE_05: Boot checks reserved word for key/checksum
// RULE_06: Handlers always start in 32-bit state
// RULE_07: Each exception mode banks stack and link
// RULE_08: Fast mode also banks registers eight-twelve
// RULE_09: Sixteen standard registers visible
// RULE_10: Link gets return or exception address
// RULE_11: Software sets downward stacks per mode
// RULE_12: 32x32 multiply and accumulate, 64-bit result
// RULE_13: Breakpoint or watchpoint halts into debug
// RULE_14: Debug registers programmed only via test port
// RULE_15: Fast interrupt latency at most 50 cycles
// RULE_16: Latency 42 without load-multiple, 22 compressed
// RULE_17: Normal interrupt latency has no bound
// RULE_18: Shared 32-bit bus, 8/16/32 transfers
// RULE_19: Power-down wakes only on listed events
// RULE_20: Core clock at most 20.48 MHz; SYS_MHZ is 250.0 and the bench clocks sys_clk at 250 MHz
// RULE_21: Entry saves status, masks, switches, vectors
package cxl_pkg;
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
  localparam logic [31:0] VEC_PABORT = 32'h0000_000c;
  localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
  localparam logic [31:0] VEC_RESERVED = 32'h0000_0014;
  localparam logic [31:0] VEC_NORMAL = 32'h0000_0018;
  localparam logic [31:0] VEC_FAST = 32'h0000_001c;
  localparam logic [31:0] BOOT_KEY = 32'h2701_1970;
  localparam logic [31:0] STACK_TOP = 32'h0004_0ffc;
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_NORMAL = 5'h12;
  localparam logic [4:0] MODE_SUPER = 5'h13;
  localparam logic [4:0] MODE_ABORT = 5'h17;
  localparam logic [4:0] MODE_UNDEF = 5'h1b;
  localparam int CSR_IRQ_MASK = 7;
  localparam int CSR_FIQ_MASK = 6;
  localparam int CSR_STATE = 5;
  localparam logic [31:0] CSR_RESET = 32'h0000_00d3;
  localparam int BANK_SP = 13;
  localparam int BANK_LR = 14;
  localparam int NUM_BANKS = 6;
  localparam logic [2:0] BK_USER = 3'h0;
  localparam logic [2:0] BK_FAST = 3'h1;
  localparam logic [2:0] BK_NORMAL = 3'h2;
  localparam logic [2:0] BK_SUPER = 3'h3;
  localparam logic [2:0] BK_ABORT = 3'h4;
  localparam logic [2:0] BK_UNDEF = 3'h5;
  localparam real CORE_MAX_MHZ = 20.48;
  localparam real SYS_MHZ = 250.0;
  localparam int FAST_LAT_MAX = 50;
  localparam int FAST_LAT_NO_LM = 42;
  localparam int FAST_LAT_16B = 22;
  localparam int ENTRY_CYCLES = 2;
  typedef enum logic [2:0] {
    EX_NONE, EX_DABORT, EX_FAST, EX_NORMAL, EX_PABORT, EX_UNDEF, EX_TRAP
  } cxl_exc_t;
endpackage

// *** cxl_exception_unit.sv ***
/*
  Exception entry, register banking, boot check, debug halt, multiplier,
  wake logic and latency watch for the embedded core.
  Assumes the pipeline raises aborts, undefined and trap as same-clock
  pulses; interrupt, wake and debug requests arrive from outside.
*/
`timescale 1ns/1ns
module cxl_exception_unit
  import cxl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Asynchronous requests
  input wire logic fast_interrupt_req,
  input wire logic normal_interrupt_req,
  // Core pipeline events
  input wire logic data_abort,
  input wire logic prefetch_abort,
  input wire logic undef_instr,
  input wire logic software_trap,
  input wire logic branch_link,
  input wire logic [31:0] return_addr,
  input wire logic [31:0] current_addr,
  input wire logic compressed_state,
  input wire logic load_multiple_instruction,
  input wire logic exc_return,
  // Register file access
  input wire logic [3:0] reg_sel,
  input wire logic reg_we,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Boot check
  input wire logic boot_valid,
  input wire logic [31:0] boot_word,
  input wire logic [31:0] page_checksum,
  output logic boot_user,
  output logic boot_download,
  // Debug via test port
  input wire logic tp_write,
  input wire logic tp_sel_watch,
  input wire logic [31:0] tp_data,
  input wire logic tp_resume,
  input wire logic [31:0] data_addr,
  output logic debug_halt,
  // Multiplier
  input wire logic mul_start,
  input wire logic mul_acc,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  input wire logic [63:0] mul_acc_in,
  output logic [63:0] mul_result,
  // Power down and wake
  input wire logic power_down,
  input wire logic wake_conv_ready,
  input wire logic wake_comparator,
  input wire logic wake_timer,
  input wire logic wake_serial,
  output logic core_asleep,
  // Exception outputs
  output logic exc_taken,
  output logic [31:0] exc_vector,
  output logic [4:0] cur_mode,
  output logic wide_state,
  output logic [31:0] saved_status,
  output logic fast_latency_over
);
  logic [1:0] fiq_sync;
  logic [1:0] irq_sync;
  logic [31:0] status;
  logic [31:0] spsr [NUM_BANKS];
  logic [31:0] gpr [16];
  logic [31:0] bank_sp [NUM_BANKS];
  logic [31:0] bank_lr [NUM_BANKS];
  logic [31:0] fast_hi [5];
  logic [31:0] break_addr;
  logic [31:0] watch_addr;
  logic [7:0] fiq_wait;
  logic boot_done;

  function automatic logic [2:0] bank_of(input logic [4:0] m);
    case (m)
      MODE_FAST: bank_of = BK_FAST;
      MODE_NORMAL: bank_of = BK_NORMAL;
      MODE_SUPER: bank_of = BK_SUPER;
      MODE_ABORT: bank_of = BK_ABORT;
      MODE_UNDEF: bank_of = BK_UNDEF;
      default: bank_of = BK_USER;
    endcase
  endfunction

  wire fiq_live = fiq_sync[1] && !status[CSR_FIQ_MASK];
  wire irq_live = irq_sync[1] && !status[CSR_IRQ_MASK];
  wire awake = !core_asleep && !debug_halt;
  // Fixed arbitration; undefined and trap are exclusive so share a level
  cxl_exc_t next_exc;
  assign next_exc = !awake ? EX_NONE :
    data_abort ? EX_DABORT : // RULE_03
    fiq_live ? EX_FAST : // RULE_02
    irq_live ? EX_NORMAL :
    prefetch_abort ? EX_PABORT :
    undef_instr ? EX_UNDEF : // RULE_04
    software_trap ? EX_TRAP : EX_NONE;

  logic [31:0] next_vec;
  logic [4:0] next_mode;
  always_comb begin
    next_vec = VEC_RESET;
    next_mode = status[4:0];
    case (next_exc) // RULE_01
      EX_DABORT: begin next_vec = VEC_DABORT; next_mode = MODE_ABORT; end
      EX_FAST: begin next_vec = VEC_FAST; next_mode = MODE_FAST; end
      EX_NORMAL: begin next_vec = VEC_NORMAL; next_mode = MODE_NORMAL; end
      EX_PABORT: begin next_vec = VEC_PABORT; next_mode = MODE_ABORT; end
      EX_UNDEF: begin next_vec = VEC_UNDEF; next_mode = MODE_UNDEF; end
      EX_TRAP: begin next_vec = VEC_TRAP; next_mode = MODE_SUPER; end
      default: begin next_vec = VEC_RESET; next_mode = status[4:0]; end
    endcase
  end

  wire take = next_exc != EX_NONE;
  wire [2:0] cur_bank = bank_of(status[4:0]);
  wire [2:0] new_bank = bank_of(next_mode);
  wire in_fast = status[4:0] == MODE_FAST;
  wire hi_sel = reg_sel >= 4'd8 && reg_sel <= 4'd12;
  wire [2:0] hi_idx = 3'(reg_sel - 4'd8);

  // Read mux: banked stack/link per mode, fast mode also banks 8..12
  assign reg_rdata = reg_sel == 4'(BANK_SP) ? bank_sp[cur_bank] : // RULE_07
    reg_sel == 4'(BANK_LR) ? bank_lr[cur_bank] :
    (in_fast && hi_sel) ? fast_hi[hi_idx] : gpr[reg_sel]; // RULE_08 RULE_09

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fiq_sync <= 2'h0;
      irq_sync <= 2'h0;
    end else begin
      fiq_sync <= {fiq_sync[0], fast_interrupt_req};
      irq_sync <= {irq_sync[0], normal_interrupt_req};
    end
  end

  // Status: entry saves old status, masks normal interrupts, 32-bit state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= CSR_RESET;
      for (int i = 0; i < NUM_BANKS; i++) spsr[i] <= 32'h0;
    end else if (take) begin
      spsr[new_bank] <= status; // RULE_21
      status[CSR_IRQ_MASK] <= 1'b1; // RULE_21
      if (next_exc == EX_FAST) status[CSR_FIQ_MASK] <= 1'b1;
      status[CSR_STATE] <= 1'b0; // RULE_06
      status[4:0] <= next_mode; // RULE_21
    end else if (exc_return && awake) begin
      status <= spsr[cur_bank];
    end else if (awake) begin
      status[CSR_STATE] <= compressed_state;
    end
  end

  // Register file writes and link capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) gpr[i] <= 32'h0;
      for (int i = 0; i < 5; i++) fast_hi[i] <= 32'h0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        bank_sp[i] <= STACK_TOP; // RULE_11
        bank_lr[i] <= 32'h0;
      end
    end else if (take) begin
      bank_lr[new_bank] <= current_addr; // RULE_10
    end else if (awake && branch_link) begin
      bank_lr[cur_bank] <= return_addr; // RULE_10
    end else if (reg_we) begin
      if (reg_sel == 4'(BANK_SP)) bank_sp[cur_bank] <= reg_wdata;
      else if (reg_sel == 4'(BANK_LR)) bank_lr[cur_bank] <= reg_wdata;
      else if (in_fast && hi_sel) fast_hi[hi_idx] <= reg_wdata; // RULE_08
      else gpr[reg_sel] <= reg_wdata;
    end
  end

  // Entry outputs are registered one cycle after arbitration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_taken <= 1'b0;
      exc_vector <= VEC_RESET;
      saved_status <= 32'h0;
    end else begin
      exc_taken <= take;
      exc_vector <= take ? next_vec : exc_vector;
      saved_status <= take ? status : saved_status;
    end
  end
  assign cur_mode = status[4:0];
  assign wide_state = !status[CSR_STATE];

  // Boot check runs once after reset on the first valid fetch of 0x14
  wire boot_ok = boot_word == BOOT_KEY || boot_word == page_checksum;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done <= 1'b0;
      boot_user <= 1'b0;
      boot_download <= 1'b0;
    end else if (boot_valid && !boot_done) begin
      boot_done <= 1'b1;
      boot_user <= boot_ok; // RULE_05
      boot_download <= !boot_ok; // RULE_05
    end
  end

  // Debug match registers are loaded only from the test port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_addr <= 32'hffff_ffff;
      watch_addr <= 32'hffff_ffff;
      debug_halt <= 1'b0;
    end else begin
      if (tp_write && tp_sel_watch) watch_addr <= tp_data; // RULE_14
      if (tp_write && !tp_sel_watch) break_addr <= tp_data; // RULE_14
      if (current_addr == break_addr || data_addr == watch_addr)
        debug_halt <= 1'b1; // RULE_13
      else if (tp_resume)
        debug_halt <= 1'b0;
    end
  end

  // Multiplier: single-cycle 32x32 with optional accumulate
  wire [63:0] product = mul_a * mul_b;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mul_result <= 64'h0;
    else if (mul_start)
      mul_result <= mul_acc ? product + mul_acc_in : product; // RULE_12
  end

  // Wake sources are already synchronous events from on-chip blocks
  wire wake_any = wake_conv_ready | wake_comparator | wake_timer |
    wake_serial;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      core_asleep <= 1'b0; // RULE_19
    else if (wake_any)
      core_asleep <= 1'b0; // RULE_19
    else if (power_down)
      core_asleep <= 1'b1;
  end

  // Latency watch: normal interrupts are never timed, as fast ones may
  // starve them indefinitely
  logic [7:0] lat_limit;
  assign lat_limit = compressed_state ? 8'(FAST_LAT_16B) : // RULE_16
    load_multiple_instruction ? 8'(FAST_LAT_MAX) : 8'(FAST_LAT_NO_LM);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fiq_wait <= 8'h0;
      fast_latency_over <= 1'b0;
    end else if (fiq_live && next_exc != EX_FAST && awake) begin
      fiq_wait <= fiq_wait + 8'h1;
      if (fiq_wait + 8'(ENTRY_CYCLES) > lat_limit)
        fast_latency_over <= 1'b1; // RULE_15 RULE_17
    end else begin
      fiq_wait <= 8'h0;
    end
  end
endmodule

// *** cxl_irq_src.sv ***
/*
  Interrupt source model: raises fast and normal requests on command.
  Assumes the bench pulses the go and ack inputs on clock edges.
*/
`timescale 1ns/1ns
module cxl_irq_src (
  // Clock and commands
  input wire logic sys_clk,
  input wire logic fast_go,
  input wire logic normal_go,
  input wire logic irq_ack,
  // Request levels
  output logic fast_interrupt_req = 1'b0,
  output logic normal_interrupt_req = 1'b0
);
  // Held until serviced, like a peripheral flag; level, never a pulse
  always @(posedge sys_clk) begin
    if (irq_ack) begin
      fast_interrupt_req <= 1'b0;
      normal_interrupt_req <= 1'b0;
    end else begin
      if (fast_go) fast_interrupt_req <= 1'b1;
      if (normal_go) normal_interrupt_req <= 1'b1;
    end
  end
endmodule

// *** cxl_exception_unit_sva.sv ***
/*
  Checker for exception entry, state, multiplier and stalls.
  Assumes it is bound to the unit and sees only its ports.
*/
`timescale 1ns/1ns
module cxl_exception_unit_sva
  import cxl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Requests and events
  input wire logic fast_interrupt_req,
  input wire logic normal_interrupt_req,
  input wire logic data_abort,
  input wire logic prefetch_abort,
  input wire logic undef_instr,
  input wire logic software_trap,
  // Multiplier
  input wire logic mul_start,
  input wire logic mul_acc,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  input wire logic [63:0] mul_acc_in,
  input wire logic [63:0] mul_result,
  // Core state
  input wire logic debug_halt,
  input wire logic core_asleep,
  input wire logic exc_taken,
  input wire logic [31:0] exc_vector,
  input wire logic [4:0] cur_mode,
  input wire logic wide_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire awake = !core_asleep && !debug_halt;
  // A synced interrupt may legally win, so judge only idle request lines
  sequence s_quiet;
    (!fast_interrupt_req && !normal_interrupt_req) [*4];
  endsequence
  sequence s_enter(logic [31:0] v, logic [4:0] m);
    exc_taken && exc_vector == v && cur_mode == m;
  endsequence
  AST_DABORT: assert property (
    data_abort && awake |=> s_enter(VEC_DABORT, MODE_ABORT))
    else $error("data abort entry wrong");
  AST_PABORT: assert property (
    s_quiet ##0 (prefetch_abort && !data_abort && awake)
    |=> s_enter(VEC_PABORT, MODE_ABORT))
    else $error("prefetch abort entry wrong");
  AST_UNDEF: assert property (
    s_quiet ##0 (undef_instr && !data_abort && !prefetch_abort && awake)
    |=> s_enter(VEC_UNDEF, MODE_UNDEF))
    else $error("undefined entry wrong");
  AST_TRAP: assert property (
    s_quiet ##0 (software_trap && !data_abort && !prefetch_abort && awake)
    |=> s_enter(VEC_TRAP, MODE_SUPER))
    else $error("trap entry wrong");
  AST_FAST: assert property (
    exc_taken && cur_mode == MODE_FAST |-> exc_vector == VEC_FAST)
    else $error("fast vector wrong");
  AST_WIDE: assert property (
    exc_taken |-> wide_state)
    else $error("handler not in wide state");
  AST_MUL: assert property (
    mul_start |=> mul_result == 64'($past(mul_a)) * 64'($past(mul_b))
      + ($past(mul_acc) ? $past(mul_acc_in) : 64'h0))
    else $error("multiplier result wrong");
  AST_SILENT: assert property (
    core_asleep || debug_halt |=> !exc_taken)
    else $error("entry while stalled");
endmodule
bind cxl_exception_unit cxl_exception_unit_sva u_sva (.*);

// *** tb.sv ***
/*
  Bench for the exception unit, one task per scenario.
  Assumes cxl_irq_src on the request side.
*/
`timescale 1ns/1ns
module tb;
  import cxl_pkg::*;
  logic sys_clk = 0, rst_n = 0, fast_go = 0, normal_go = 0, irq_ack = 0;
  logic data_abort = 0, prefetch_abort = 0, undef_instr = 0;
  logic software_trap = 0, branch_link = 0, compressed_state = 0;
  logic load_multiple_instruction = 0, exc_return = 0, reg_we = 0;
  logic [31:0] return_addr = 0, current_addr = 32'h0000_0200;
  logic [31:0] reg_wdata = 0, boot_word = 0, page_checksum = 0;
  logic [31:0] tp_data = 0, data_addr = 0, mul_a = 0, mul_b = 0;
  logic [3:0] reg_sel = 0;
  logic boot_valid = 0, tp_write = 0, tp_sel_watch = 0, tp_resume = 0;
  logic mul_start = 0, mul_acc = 0, power_down = 0, wake_serial = 0;
  logic wake_conv_ready = 0, wake_comparator = 0, wake_timer = 0;
  logic [63:0] mul_acc_in = 0, mul_result;
  logic [31:0] reg_rdata, exc_vector, saved_status;
  logic [4:0] cur_mode;
  logic boot_user, boot_download, debug_halt, core_asleep, exc_taken;
  logic wide_state, fast_latency_over, fast_interrupt_req;
  logic normal_interrupt_req;
  int n_mismatch = 0, compares = 0;
  cxl_exception_unit dut (.*);
  cxl_irq_src u_src (.*);
  initial forever #2 sys_clk = ~sys_clk;
  task automatic results;
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc;
    @(posedge sys_clk);
  endtask
  task automatic do_reset;
    cyc;
    rst_n <= 0;
    reg_sel <= 4'hd;
    repeat (4) cyc;
    #1 chk(cur_mode, MODE_SUPER);
    chk(reg_rdata, STACK_TOP);
    cyc;
    rst_n <= 1;
  endtask
  task automatic pulse(input logic [3:0] ev);
    cyc;
    {data_abort, prefetch_abort, undef_instr, software_trap} <= ev;
    cyc;
    {data_abort, prefetch_abort, undef_instr, software_trap} <= 4'h0;
  endtask
  task automatic ret;
    cyc;
    exc_return <= 1;
    cyc;
    exc_return <= 0;
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    cyc;
    reg_sel <= s;
    reg_we <= 1;
    reg_wdata <= d;
    cyc;
    reg_we <= 0;
  endtask
  task automatic take(input logic [3:0] ev, input logic [31:0] v,
                      input logic [4:0] m, input logic c);
    cyc;
    compressed_state <= c;
    reg_sel <= 4'he;
    pulse(ev);
    #1 chk(exc_vector, v);
    chk(cur_mode, m);
    chk(wide_state, 1'b1);
    chk(saved_status[4:0], MODE_SUPER);
    chk(reg_rdata, current_addr);
    ret;
    compressed_state <= 0;
  endtask
  task automatic t_bank;
    wr(4'hd, 32'h0003_0000);
    pulse(4'h8);
    wr(4'hd, 32'h0003_1000);
    ret;
    #1 chk(reg_rdata, 32'h0003_0000);
    pulse(4'h8);
    #1 chk(reg_rdata, 32'h0003_1000);
    ret;
    branch_link <= 1;
    return_addr <= 32'h0000_0abc;
    reg_sel <= 4'he;
    cyc;
    branch_link <= 0;
    #1 chk(reg_rdata, 32'h0000_0abc);
  endtask
  task automatic t_masked;
    cyc;
    fast_go <= 1;
    normal_go <= 1;
    cyc;
    fast_go <= 0;
    normal_go <= 0;
    repeat (8) begin
      cyc;
      #1 chk(exc_taken, 1'b0);
    end
    cyc;
    irq_ack <= 1;
    cyc;
    irq_ack <= 0;
  endtask
  task automatic t_mul(input logic c, input logic [31:0] a, b,
                       input logic [63:0] acc, e);
    cyc;
    mul_start <= 1;
    mul_acc <= c;
    mul_a <= a;
    mul_b <= b;
    mul_acc_in <= acc;
    cyc;
    mul_start <= 0;
    #1 chk(mul_result, e);
  endtask
  task automatic t_dbg(input logic w, input logic [31:0] a);
    cyc;
    tp_write <= 1;
    tp_sel_watch <= w;
    tp_data <= a;
    cyc;
    tp_write <= 0;
    if (w) data_addr <= a;
    else current_addr <= a;
    for (int i = 0; i < 20 && debug_halt !== 1'b1; i++) begin
      cyc;
      #1;
    end
    if (debug_halt !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t no halt", $time);
      results;
    end
    pulse(4'h8);
    #1 chk(exc_taken, 1'b0);
    cyc;
    tp_resume <= 1;
    current_addr <= 32'h0000_0200;
    data_addr <= 0;
    cyc;
    tp_resume <= 0;
    #1 chk(debug_halt, 1'b0);
  endtask
  task automatic t_sleep(input logic [3:0] wk);
    cyc;
    power_down <= 1;
    cyc;
    power_down <= 0;
    pulse(4'h8);
    #1 chk({core_asleep, exc_taken}, 2'b10);
    cyc;
    {wake_conv_ready, wake_comparator, wake_timer, wake_serial} <= wk;
    cyc;
    {wake_conv_ready, wake_comparator, wake_timer, wake_serial} <= 4'h0;
    #1 chk(core_asleep, 1'b0);
  endtask
  // Reset leaves a cleared saved copy, so a return unmasks both interrupts
  task automatic t_fast;
    do_reset;
    ret;
    fast_go <= 1;
    normal_go <= 1;
    cyc;
    fast_go <= 0;
    normal_go <= 0;
    for (int i = 0; i < 20 && exc_taken !== 1'b1; i++) begin
      cyc;
      #1;
    end
    chk(exc_taken, 1'b1);
    chk(exc_vector, VEC_FAST);
    chk(cur_mode, MODE_FAST);
    cyc;
    irq_ack <= 1;
    cyc;
    irq_ack <= 0;
  endtask
  task automatic t_boot(input logic [31:0] w, s, input logic u);
    do_reset;
    boot_valid <= 1;
    boot_word <= w;
    page_checksum <= s;
    cyc;
    boot_valid <= 0;
    #1 chk({boot_user, boot_download}, {u, ~u});
  endtask
  initial begin
    do_reset;
    take(4'he, VEC_DABORT, MODE_ABORT, 1'b0);
    take(4'h6, VEC_PABORT, MODE_ABORT, 1'b1);
    take(4'h2, VEC_UNDEF, MODE_UNDEF, 1'b1);
    take(4'h1, VEC_TRAP, MODE_SUPER, 1'b1);
    t_bank;
    t_masked;
    t_mul(1'b0, 32'hffff_ffff, 32'hffff_ffff, 64'h0,
          64'hffff_fffe_0000_0001);
    t_mul(1'b1, 32'h0001_0000, 32'h0001_0000, 64'h1_0000_0005,
          64'h2_0000_0005);
    t_dbg(1'b0, 32'h0000_0300);
    t_dbg(1'b1, 32'h0000_0400);
    for (int k = 0; k < 4; k++) t_sleep(4'h8 >> k);
    t_fast;
    chk(fast_latency_over, 1'b0);
    t_boot(BOOT_KEY, 32'h0000_1234, 1'b1);
    t_boot(32'h0000_5a5a, 32'h0000_5a5a, 1'b1);
    t_boot(32'h0000_5a5a, 32'h0000_1111, 1'b0);
    results;
  end
endmodule
